//--- shared/wbp_pkg.sv
// constants shared by the weapons-bus packetizer and its word formatter
// assumes a single recorder clock; no timescale in packages
package wbp_pkg;

	// transaction shape
	localparam int WBP_TXN_WORDS = 6;        // words in one bus transaction
	localparam int WBP_HALVES_PER_WORD = 2;  // 16-bit halves per stored word
	localparam int WBP_BYTES_PER_WORD = 4;   // bytes per stored 32-bit word
	localparam int WBP_CHANNEL_SPECIFIC_WORD_HALVES = 2;      // halves of the leading count word

	// layout of one transaction block, in 16-bit halves
	localparam int WBP_OFS_TS = 0;           // four time-stamp halves
	localparam int WBP_TS_HALVES = 4;
	localparam int WBP_OFS_STATUS = 4;       // data header status half
	localparam int WBP_OFS_LENGTH = 5;       // data header length half
	localparam int WBP_OFS_DATA = 6;         // first bus word, upper half
	localparam int WBP_BLOCK_HALVES = 18;    // header plus six words

	// data header status bit positions
	localparam int WBP_ST_ERR = 15;          // transaction_error_flag
	localparam int WBP_ST_RST = 14;          // master_reset_seen_flag
	localparam int WBP_ST_TMO = 13;          // transaction_timeout_flag
	localparam int WBP_ST_NOSTAT = 6;        // missing_status_flag
	localparam int WBP_ST_NOECHO = 3;        // missing_echo_flag

	// gap measurement; thresholds in ns, the monitor's gap count in 50 ns units
	localparam int WBP_GAP_W = 12;
	localparam int WBP_GAP_UNIT_NS = 50;
	localparam int WBP_GAP_T1_NS = 1150;
	localparam int WBP_GAP_T3_NS = 2750;
	localparam int WBP_GAP_T4_NS = 4350;
	localparam int WBP_GAP_T5_NS = 5950;
	localparam int WBP_GAP_T6_NS = 7550;
	localparam int WBP_GAP_T7_NS = 9150;
	localparam logic [2:0] WBP_GAP_NA = 3'h0;
	localparam logic [2:0] WBP_GAP_B1 = 3'h1;
	localparam logic [2:0] WBP_GAP_B3 = 3'h3;
	localparam logic [2:0] WBP_GAP_B4 = 3'h4;
	localparam logic [2:0] WBP_GAP_B5 = 3'h5;
	localparam logic [2:0] WBP_GAP_B6 = 3'h6;
	localparam logic [2:0] WBP_GAP_B7 = 3'h7;

	// source_bus_code values
	localparam logic [2:0] WBP_BUS_LEFT_A = 3'h7;
	localparam logic [2:0] WBP_BUS_LEFT_B = 3'h6;
	localparam logic [2:0] WBP_BUS_RIGHT_A = 3'h5;
	localparam logic [2:0] WBP_BUS_RIGHT_B = 3'h4;
	localparam logic [2:0] WBP_BUS_RESP_AB = 3'h3;
	localparam logic [2:0] WBP_BUS_RESP_A = 3'h2;
	localparam logic [2:0] WBP_BUS_RESP_B = 3'h1;
	localparam logic [2:0] WBP_BUS_INCOMPLETE = 3'h0;

	// register map, byte addresses
	localparam logic [3:0] WBP_REG_CTRL = 4'h0;
	localparam logic [3:0] WBP_REG_STATUS = 4'h4;
	localparam logic [3:0] WBP_REG_PACKETS = 4'h8;
	localparam int WBP_CTRL_ENABLE = 0;
	localparam int WBP_CTRL_FLUSH = 1;
	localparam int WBP_CTRL_MAX_LSB = 8;
	localparam int WBP_CTRL_MAX_W = 8;
	localparam logic [31:0] WBP_CTRL_RESET = 32'h0000_0001;

endpackage

//--- verification/wbp_packetizer_assertions.sv
// concurrent checks on the packetizer's register bus and body stream
// bound to every wbp_packetizer; sees its ports only
`timescale 1ns/100ps
`default_nettype none
module wbp_packetizer_assertions import wbp_pkg::*; #(
	parameter int MAX_TXN = 4  // same limit as the design
) (
	input wire logic mclk_i,                 // recorder clock
	input wire logic sys_rst_i,              // async reset
	input wire logic avs_read_i,             // read request
	input wire logic avs_write_i,            // write request
	input wire logic [31:0] avs_readdata_o,  // read data
	input wire logic avs_waitrequest_o,      // stall
	input wire logic [15:0] pkt_data_o,      // body half
	input wire logic pkt_valid_o,            // half valid
	input wire logic pkt_sop_o,              // first half
	input wire logic pkt_eop_o,              // last half
	input wire logic pkt_ready_i             // sink takes half
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	logic [15:0] idx_q;
	// position of the presented half within the body
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			idx_q <= 16'h0;
		else if (pkt_valid_o && pkt_ready_i)
			idx_q <= pkt_eop_o ? 16'h0 : idx_q + 16'h1;
	end
	// bus answers after one wait cycle, low for one cycle only
	chk_wait_one: assert property ((avs_read_i || avs_write_i) &&
		avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("waitrequest not low for exactly one cycle");
	chk_rdata_hold: assert property (!(avs_read_i && avs_waitrequest_o)
		|=> $stable(avs_readdata_o)) else $error("read data moved");
	// a stalled half must not change under the sink
	chk_stream_hold: assert property (pkt_valid_o && !pkt_ready_i |=>
		pkt_valid_o && $stable(pkt_data_o) && $stable({pkt_sop_o, pkt_eop_o}))
		else $error("stream half changed while stalled");
	chk_no_bubble: assert property (pkt_valid_o && pkt_ready_i && !pkt_eop_o
		|=> pkt_valid_o) else $error("gap inside body");
	chk_sop_place: assert property (pkt_valid_o |->
		pkt_sop_o == (idx_q == 16'h0)) else $error("start flag misplaced");
	chk_count_lo: assert property (pkt_valid_o && pkt_sop_o |->
		pkt_data_o != 16'h0 && pkt_data_o <= MAX_TXN)
		else $error("count out of range");
	chk_count_hi: assert property (pkt_valid_o && idx_q == 16'h1 |->
		pkt_data_o == 16'h0) else $error("count upper half not zero");
	chk_stamp_top: assert property (pkt_valid_o && idx_q == 16'h5 |->
		pkt_data_o == 16'h0) else $error("stamp top not zero");
	chk_status_rsv: assert property (pkt_valid_o && idx_q == 16'h6 |->
		(pkt_data_o & 16'h1FB7) == 16'h0) else $error("reserved status bit");
	chk_len_first: assert property (pkt_valid_o && idx_q == 16'h7 |->
		pkt_data_o[1:0] == 2'h0 && pkt_data_o >= 16'h4 &&
		pkt_data_o <= 16'h18) else $error("length not whole words");
	chk_body_min: assert property (pkt_valid_o && pkt_eop_o |->
		idx_q >= 16'h9) else $error("body too short");
endmodule
bind wbp_packetizer wbp_packetizer_assertions #(.MAX_TXN(MAX_TXN)) chk_inst (
	.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .pkt_data_o(pkt_data_o),
	.pkt_valid_o(pkt_valid_o), .pkt_sop_o(pkt_sop_o),
	.pkt_eop_o(pkt_eop_o), .pkt_ready_i(pkt_ready_i));
`default_nettype wire

//--- verification/wbp_packetizer_tb.sv
// self-checking bench for the packetizer: monitor words in, bodies out
// assumes wbp_sink as stream partner and the bound checker
`timescale 1ns/100ps
`default_nettype none
module wbp_packetizer_tb import wbp_pkg::*; ;
	typedef struct packed {
		logic [2:0] bus; logic [11:0] gap; logic gv; logic [2:0] code;
		logic [6:0] fl; // bit, parity, error, reset, timeout, status, echo
	} wbp_row_type;
	// one row per bus code; gap counts sit just above each band edge
	localparam wbp_row_type ROWS [8] = '{
		'{3'h7, 12'h018, 1'h1, 3'h1, 7'h00}, '{3'h6, 12'h038, 1'h1, 3'h3, 7'h40},
		'{3'h5, 12'h058, 1'h1, 3'h4, 7'h20}, '{3'h4, 12'h078, 1'h1, 3'h5, 7'h10},
		'{3'h3, 12'h098, 1'h1, 3'h6, 7'h08}, '{3'h2, 12'h0B8, 1'h1, 3'h7, 7'h04},
		'{3'h1, 12'h017, 1'h1, 3'h0, 7'h02}, '{3'h0, 12'h0B8, 1'h0, 3'h0, 7'h01}};
	localparam logic [47:0] T0 = 48'h1234_5678_9ABC;
	logic mclk_i = 1'h0, sys_rst_i = 1'h1, avs_read_i = 1'h0, avs_write_i = 1'h0;
	logic mon_valid_i = 1'h0, mon_first_i = 1'h0, mon_last_i = 1'h0;
	logic mon_gap_valid_i = 1'h0, mon_bit_err_i = 1'h0, mon_par_err_i = 1'h0;
	logic mon_error_i = 1'h0, mon_master_reset_i = 1'h0, mon_timeout_i = 1'h0;
	logic mon_status_missing_i = 1'h0, mon_echo_missing_i = 1'h0, stall = 1'h0;
	logic [3:0] avs_address_i = 4'h0;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
	logic [47:0] mon_time_i = 48'h0;
	logic [25:0] mon_word_i = 26'h0;
	logic [2:0] mon_bus_i = 3'h0;
	logic [WBP_GAP_W-1:0] mon_gap_i = '0;
	logic avs_waitrequest_o, mon_ready_o, pkt_valid_o, pkt_sop_o, pkt_eop_o;
	logic pkt_ready_i;
	logic [15:0] pkt_data_o;
	int fails = 0;
	int checks = 0;
	wbp_packetizer #(.MAX_TXN(4)) wbp_packetizer_inst (.mclk_i, .sys_rst_i,
		.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_readdata_o, .avs_waitrequest_o, .mon_valid_i, .mon_ready_o,
		.mon_first_i, .mon_last_i, .mon_time_i, .mon_word_i, .mon_bus_i,
		.mon_gap_i, .mon_gap_valid_i, .mon_bit_err_i, .mon_par_err_i,
		.mon_error_i, .mon_master_reset_i, .mon_timeout_i,
		.mon_status_missing_i, .mon_echo_missing_i, .pkt_data_o,
		.pkt_valid_o, .pkt_sop_o, .pkt_eop_o, .pkt_ready_i);
	wbp_sink wbp_sink_inst (.mclk_i, .sys_rst_i, .stall_i(stall),
		.pkt_data_i(pkt_data_o), .pkt_valid_i(pkt_valid_o),
		.pkt_sop_i(pkt_sop_o), .pkt_eop_i(pkt_eop_o), .pkt_ready_o(pkt_ready_i));
	// 250 MHz recorder clock
	initial forever #2 mclk_i = ~mclk_i;
	// raw word: sync and parity set so dropping them shows
	function automatic logic [25:0] wv(int k, int j);
		return {1'h1, 8'(k * 16 + j), 16'(16'hA5C3 ^ (j * 16'h1111)), 1'h1};
	endfunction
	function automatic logic [15:0] st(int k);
		logic [6:0] f;
		f = ROWS[k].fl;
		return {(|f[6:4]) | (|f[2:0]), f[3], f[2], 6'h0, f[1], 2'h0, f[0], 3'h0};
	endfunction
	task automatic end_sim;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cmp(logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one avalon cycle, held until waitrequest is sampled low
	task automatic bus(logic we, logic [3:0] a, logic [31:0] wd);
		int t;
		t = 0;
		@(posedge mclk_i);
		avs_address_i <= a;
		avs_writedata_i <= wd;
		avs_read_i <= !we;
		avs_write_i <= we;
		@(posedge mclk_i);
		while (avs_waitrequest_o && t < 50) begin
			t++;
			@(posedge mclk_i);
		end
		rd = avs_readdata_o;
		avs_read_i <= 1'h0;
		avs_write_i <= 1'h0;
		if (t == 50)
			fails++;
	endtask
	// offers nw words of row k; fin closes the transaction
	task automatic send(int k, int nw, bit fin);
		int t;
		for (int j = 0; j < nw; j++) begin
			mon_valid_i <= 1'h1;
			mon_first_i <= j == 0;
			mon_last_i <= fin && j == nw - 1;
			mon_time_i <= T0 + 48'(k);
			mon_word_i <= wv(k, j);
			mon_bus_i <= ROWS[k].bus;
			mon_gap_i <= ROWS[k].gap;
			mon_gap_valid_i <= ROWS[k].gv;
			mon_bit_err_i <= j == 2 && ROWS[k].fl[6];
			mon_par_err_i <= j == 2 && ROWS[k].fl[5];
			{mon_error_i, mon_master_reset_i, mon_timeout_i} <= ROWS[k].fl[4:2];
			{mon_status_missing_i, mon_echo_missing_i} <= ROWS[k].fl[1:0];
			t = 0;
			@(posedge mclk_i);
			while (!mon_ready_o && t < 400) begin
				t++;
				@(posedge mclk_i);
			end
			if (t == 400)
				fails++;
		end
		mon_valid_i <= 1'h0;
		mon_word_i <= ~mon_word_i;
		// one idle edge so a following call never re-raises valid at once
		@(posedge mclk_i);
	endtask
	task automatic wait_pkt(int p);
		int t;
		t = 0;
		while (wbp_sink_inst.pkts < p && t < 2000) begin
			t++;
			@(posedge mclk_i);
		end
		if (t == 2000)
			fails++;
	endtask
	// compares one 18-half transaction block starting at half b
	task automatic chk_txn(int k, int b);
		logic [47:0] tm;
		logic [25:0] w;
		tm = T0 + 48'(k);
		cmp(wbp_sink_inst.got[b], tm[15:0]);
		cmp(wbp_sink_inst.got[b + 1], tm[31:16]);
		cmp(wbp_sink_inst.got[b + 2], tm[47:32]);
		cmp(wbp_sink_inst.got[b + 3], 16'h0);
		cmp(wbp_sink_inst.got[b + 4], st(k));
		cmp(wbp_sink_inst.got[b + 5], 16'h18);
		for (int j = 0; j < 6; j++) begin
			w = wv(k, j);
			cmp(wbp_sink_inst.got[b + 6 + 2 * j],
				{ROWS[k].bus, ROWS[k].code, j == 2 && ROWS[k].fl[6],
				j == 2 && ROWS[k].fl[5], w[24:17]});
			cmp(wbp_sink_inst.got[b + 7 + 2 * j], w[16:1]);
		end
	endtask
	// span allows roughly forty times the expected traffic
	initial begin
		#100000;
		fails++;
		end_sim;
	end
	initial begin
		repeat (4) @(posedge mclk_i);
		sys_rst_i <= 1'h0;
		bus(1'h1, WBP_REG_CTRL, 32'h0000_0101);
		for (int k = 0; k < 8; k++) begin
			send(k, 6, 1'h1);
			wait_pkt(k + 1);
			cmp(wbp_sink_inst.n, 32'h14);
			cmp(wbp_sink_inst.got[0], 16'h1);
			cmp(wbp_sink_inst.got[1], 16'h0);
			chk_txn(k, 2);
		end
		// new first before last drops the open transaction
		send(1, 3, 1'h0);
		send(2, 6, 1'h1);
		wait_pkt(9);
		cmp(wbp_sink_inst.n, 32'h14);
		chk_txn(2, 2);
		// two per packet while the sink stalls
		stall <= 1'h1;
		bus(1'h1, WBP_REG_CTRL, 32'h0000_0201);
		send(3, 6, 1'h1);
		send(4, 6, 1'h1);
		wait_pkt(10);
		cmp(wbp_sink_inst.n, 32'h26);
		cmp(wbp_sink_inst.got[0], 16'h2);
		chk_txn(3, 2);
		chk_txn(4, 20);
		// flush closes a part-filled packet
		bus(1'h1, WBP_REG_CTRL, 32'h0000_0401);
		send(5, 6, 1'h1);
		bus(1'h0, WBP_REG_STATUS, 32'h0);
		cmp(rd, 32'h0001_0000);
		bus(1'h1, WBP_REG_CTRL, 32'h0000_0403);
		wait_pkt(11);
		cmp(wbp_sink_inst.got[0], 16'h1);
		cmp(wbp_sink_inst.n, 32'h14);
		bus(1'h0, WBP_REG_CTRL, 32'h0);
		cmp(rd, 32'h0000_0401);
		bus(1'h1, WBP_REG_PACKETS, 32'hFFFF_FFFF);
		bus(1'h0, WBP_REG_PACKETS, 32'h0);
		cmp(rd, 32'h0000_000B);
		bus(1'h0, 4'hC, 32'h0);
		cmp(rd, 32'h0);
		// short transaction: four words, length in bytes follows
		send(0, 4, 1'h1);
		bus(1'h1, WBP_REG_CTRL, 32'h0000_0403);
		wait_pkt(12);
		cmp(wbp_sink_inst.n, 32'h10);
		cmp(wbp_sink_inst.got[0], 16'h1);
		cmp(wbp_sink_inst.got[7], 16'h10);
		// second reset in mid-run restores defaults
		sys_rst_i <= 1'h1;
		repeat (4) @(posedge mclk_i);
		sys_rst_i <= 1'h0;
		bus(1'h0, WBP_REG_CTRL, 32'h0);
		cmp(rd, WBP_CTRL_RESET);
		bus(1'h0, WBP_REG_PACKETS, 32'h0);
		cmp(rd, 32'h0);
		cmp(mon_ready_o, 32'h1);
		// enable off must stop the monitor handshake
		bus(1'h1, WBP_REG_CTRL, 32'h0);
		@(posedge mclk_i);
		cmp(mon_ready_o, 32'h0);
		end_sim;
	end
endmodule
`default_nettype wire

//--- verification/wbp_sink.sv
// packet stream sink: takes body halves and keeps the last packet
// assumes the recorder clock; stall slows it to one take in four
`timescale 1ns/100ps
`default_nettype none
module wbp_sink (
	input wire logic mclk_i,           // recorder clock
	input wire logic sys_rst_i,        // async reset
	input wire logic stall_i,          // answer slowly
	input wire logic [15:0] pkt_data_i, // body half
	input wire logic pkt_valid_i,      // half valid
	input wire logic pkt_sop_i,        // first half
	input wire logic pkt_eop_i,        // last half
	output logic pkt_ready_o           // half taken
);
	logic [15:0] got [0:127];
	int n;
	int pkts;
	logic [1:0] ph_q;
	// ready moves only after an edge; capture restarts on start flag
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ph_q <= 2'h0;
			pkt_ready_o <= 1'h0;
			n <= 0;
			pkts <= 0;
		end else begin
			ph_q <= ph_q + 2'h1;
			pkt_ready_o <= !stall_i || ph_q == 2'h3;
			if (pkt_valid_i && pkt_ready_o) begin
				got[pkt_sop_i ? 0 : n] <= pkt_data_i;
				n <= pkt_sop_i ? 1 : n + 1;
				if (pkt_eop_i)
					pkts <= pkts + 1;
			end
		end
	end
endmodule
`default_nettype wire

//--- verilog/wbp_packetizer.sv
// weapons-bus transaction packetizer: captures bus words from the
// monitor, builds packet bodies and streams them out 16 bits at a time
// assumes the monitor and the stream sink share mclk_i; registers are
// reached over avalon-mm with waitrequest
//
// Operation
// R01: a transaction is six words: command, echo, command, two go/no-go, status
// R02: packets hold only whole transactions, never a split one
// R03: body opens with a 32-bit word holding the transaction count
// R04: each transaction is preceded by time stamp and data header
// R05: header length holds the byte count of the following data
// R06: status bit 15 set when any error is found
// R07: status bit 14 set when a master reset was seen
// R08: status bit 13 set on transaction time-out
// R09: status bit 6 set when the status word is missing
// R10: status bit 3 set when the echo word is missing
// R11: all other status bits are zero
// R12: time stamp is 64 bits, 48-bit relative time, top 16 zero
// R13: first word after the length is the first command word
// R14: order: stamp low half first, status, length, word upper half first
// R15: each 26-bit word becomes two halves, sync and parity dropped
// R16: first half carries code, gap, flags, bits 24-17; second bits 16-1
// R17: a three-bit code names the bus each word came from
// R18: bus codes follow the fixed left, right, response, incomplete table
// R19: gap is banded into a three-bit code, zero meaning not applicable
// R20: per-word bit-error flag set on a manchester error
// R21: per-word parity-error flag set on a parity error
// R22: transaction count is final only after the last transaction is in
`timescale 1ns/100ps
`default_nettype none
module wbp_packetizer import wbp_pkg::*; #(
	parameter int MAX_TXN = 4  // transactions held per packet at most
) (
	input wire logic mclk_i,                 // recorder clock
	input wire logic sys_rst_i,              // async reset, active high
	// avalon-mm slave
	input wire logic [3:0] avs_address_i,    // byte address
	input wire logic avs_read_i,             // read request
	input wire logic avs_write_i,            // write request
	input wire logic [31:0] avs_writedata_i, // write data
	output logic [31:0] avs_readdata_o,      // read data
	output logic avs_waitrequest_o,          // stall
	// bus monitor side
	input wire logic mon_valid_i,            // word offered
	output logic mon_ready_o,                // word taken when both high
	input wire logic mon_first_i,            // first word of transaction
	input wire logic mon_last_i,             // last word of transaction
	input wire logic [47:0] mon_time_i,      // relative time, with first
	input wire logic [25:0] mon_word_i,      // raw bus word
	input wire logic [2:0] mon_bus_i,        // source_bus_code
	input wire logic [WBP_GAP_W-1:0] mon_gap_i, // gap in 50 ns counts
	input wire logic mon_gap_valid_i,        // gap applies
	input wire logic mon_bit_err_i,          // manchester error
	input wire logic mon_par_err_i,          // parity error
	input wire logic mon_error_i,            // other error, with last
	input wire logic mon_master_reset_i,     // master reset, with last
	input wire logic mon_timeout_i,          // time-out, with last
	input wire logic mon_status_missing_i,   // no status word, with last
	input wire logic mon_echo_missing_i,     // no echo word, with last
	// packet body stream
	output logic [15:0] pkt_data_o,          // body half-word
	output logic pkt_valid_o,                // half-word valid
	output logic pkt_sop_o,                  // first half of body
	output logic pkt_eop_o,                  // last half of body
	input wire logic pkt_ready_i             // sink takes half-word
);

	localparam int DEPTH = MAX_TXN * WBP_BLOCK_HALVES;
	localparam int IW = $clog2(DEPTH + WBP_CHANNEL_SPECIFIC_WORD_HALVES) + 1;

	typedef enum logic [0:0] {WBP_CAPTURE, WBP_EMIT} wbp_state_enum_type;

	typedef struct packed {
		wbp_state_enum_type st;
		logic [DEPTH-1:0][15:0] mem;
		logic [IW-1:0] wr_ptr;
		logic [IW-1:0] base;
		logic [IW-1:0] rd_idx;
		logic [2:0] widx;
		logic in_txn;
		logic word_err;
		logic [31:0] txn_cnt;
		logic [15:0] pkt_cnt;
		logic enable;
		logic flush;
		logic [WBP_CTRL_MAX_W-1:0] max_txn;
		logic [15:0] od;
		logic ov;
		logic osop;
		logic oeop;
		logic waitreq;
		logic [31:0] rdata;
		logic mon_ready;
	} wbp_state_type;

	wbp_state_type s_q, s_d;
	logic [15:0] fmt_hi, fmt_lo;

	wbp_word_fmt u_fmt (
		.word_i(mon_word_i),
		.bus_i(mon_bus_i),
		.gap_i(mon_gap_i),
		.gap_valid_i(mon_gap_valid_i),
		.bit_err_i(mon_bit_err_i),
		.par_err_i(mon_par_err_i),
		.hi_o(fmt_hi),
		.lo_o(fmt_lo)
	);

	// next-state logic
	always_comb begin
		logic take, bus_req;
		logic [IW-1:0] b, pos;
		logic [2:0] w, nw;
		logic [15:0] stat;
		logic [31:0] lim;
		take = 1'b0;
		bus_req = 1'b0;
		b = '0;
		pos = '0;
		w = '0;
		nw = '0;
		stat = '0;
		lim = '0;
		s_d = s_q;

		// effective packet size: zero or oversize means the maximum
		if (s_q.max_txn == '0 || 32'(s_q.max_txn) > 32'(MAX_TXN))
			lim = 32'(MAX_TXN);
		else
			lim = 32'(s_q.max_txn);

		// capture a word; whole transactions only enter the buffer
		take = mon_valid_i && s_q.mon_ready;
		if (take && (mon_first_i || s_q.in_txn)) begin
			b = mon_first_i ? s_q.wr_ptr : s_q.base;
			w = mon_first_i ? 3'h0 : s_q.widx;
			if (mon_first_i) begin
				// an unfinished transaction is overwritten, not kept
				s_d.base = b;
				s_d.in_txn = 1'b1;
				s_d.word_err = 1'b0;
				pos = b + IW'(WBP_OFS_TS);
				s_d.mem[pos] = mon_time_i[15:0]; // R12 R14
				s_d.mem[pos + IW'(1)] = mon_time_i[31:16];
				s_d.mem[pos + IW'(2)] = mon_time_i[47:32];
				s_d.mem[pos + IW'(3)] = 16'h0000; // R12
			end
			// words past the sixth are dropped
			nw = w;
			if (32'(w) < 32'(WBP_TXN_WORDS)) begin // R01
				pos = b + IW'(WBP_OFS_DATA) + IW'(w) * IW'(WBP_HALVES_PER_WORD);
				s_d.mem[pos] = fmt_hi; // R13 R14
				s_d.mem[pos + IW'(1)] = fmt_lo; // R14
				nw = w + 3'h1;
			end
			s_d.widx = nw;
			s_d.word_err = (mon_first_i ? 1'b0 : s_q.word_err) |
				mon_bit_err_i | mon_par_err_i;
			if (mon_last_i) begin
				stat = '0; // R11
				stat[WBP_ST_ERR] = s_d.word_err | mon_error_i | mon_timeout_i |
					mon_status_missing_i | mon_echo_missing_i; // R06
				stat[WBP_ST_RST] = mon_master_reset_i; // R07
				stat[WBP_ST_TMO] = mon_timeout_i; // R08
				stat[WBP_ST_NOSTAT] = mon_status_missing_i; // R09
				stat[WBP_ST_NOECHO] = mon_echo_missing_i; // R10
				s_d.mem[b + IW'(WBP_OFS_STATUS)] = stat; // R04
				s_d.mem[b + IW'(WBP_OFS_LENGTH)] =
					16'(nw) * 16'(WBP_BYTES_PER_WORD); // R05
				s_d.wr_ptr = b + IW'(WBP_OFS_DATA) +
					IW'(nw) * IW'(WBP_HALVES_PER_WORD);
				s_d.in_txn = 1'b0;
				s_d.txn_cnt = s_q.txn_cnt + 32'h1; // R22
				if (s_d.txn_cnt >= lim)
					s_d.st = WBP_EMIT; // R02
			end
		end

		// flush closes the packet only between transactions
		if (s_q.st == WBP_CAPTURE && s_q.flush && !s_d.in_txn) begin
			s_d.flush = 1'b0; // R02
			if (s_d.txn_cnt != 32'h0)
				s_d.st = WBP_EMIT;
		end
		if (s_d.st == WBP_EMIT)
			s_d.flush = 1'b0;

		// body output register; refills while the sink accepts
		if (s_q.ov && pkt_ready_i)
			s_d.ov = 1'b0;
		if (s_q.st == WBP_EMIT && (!s_q.ov || pkt_ready_i)) begin
			if (s_q.rd_idx == '0)
				s_d.od = s_q.txn_cnt[15:0]; // R03
			else if (s_q.rd_idx == IW'(1))
				s_d.od = s_q.txn_cnt[31:16]; // R03
			else
				s_d.od = s_q.mem[s_q.rd_idx - IW'(WBP_CHANNEL_SPECIFIC_WORD_HALVES)]; // R14
			s_d.ov = 1'b1;
			s_d.osop = (s_q.rd_idx == '0);
			s_d.oeop = (s_q.rd_idx == s_q.wr_ptr + IW'(1));
			if (s_d.oeop) begin
				s_d.st = WBP_CAPTURE;
				s_d.rd_idx = '0;
				s_d.wr_ptr = '0;
				s_d.txn_cnt = '0;
				s_d.pkt_cnt = s_q.pkt_cnt + 16'h1;
			end else begin
				s_d.rd_idx = s_q.rd_idx + IW'(1);
			end
		end

		// avalon slave: one wait cycle, then answer with waitrequest low
		bus_req = avs_read_i || avs_write_i;
		if (bus_req && s_q.waitreq) begin
			s_d.waitreq = 1'b0;
			case (avs_address_i)
				WBP_REG_CTRL: begin
					s_d.rdata = '0;
					s_d.rdata[WBP_CTRL_ENABLE] = s_q.enable;
					s_d.rdata[WBP_CTRL_FLUSH] = s_q.flush;
					s_d.rdata[WBP_CTRL_MAX_LSB +: WBP_CTRL_MAX_W] = s_q.max_txn;
				end
				WBP_REG_STATUS:
					s_d.rdata = {s_q.txn_cnt[15:0], 13'h0000, s_q.flush,
						s_q.in_txn, (s_q.st == WBP_EMIT)};
				WBP_REG_PACKETS:
					s_d.rdata = {16'h0000, s_q.pkt_cnt};
				default:
					s_d.rdata = 32'h0000_0000;
			endcase
			// writes leave read data alone; it stands until the next read
			if (!avs_read_i)
				s_d.rdata = s_q.rdata;
		end else if (bus_req) begin
			// completing edge: write lands, request released
			s_d.waitreq = 1'b1;
			if (avs_write_i && avs_address_i == WBP_REG_CTRL) begin
				s_d.enable = avs_writedata_i[WBP_CTRL_ENABLE];
				s_d.max_txn =
					avs_writedata_i[WBP_CTRL_MAX_LSB +: WBP_CTRL_MAX_W];
				if (avs_writedata_i[WBP_CTRL_FLUSH])
					s_d.flush = 1'b1;
			end
		end else begin
			s_d.waitreq = 1'b1;
		end

		// accept words only while capturing and no close is pending between transactions
		s_d.mon_ready = (s_d.st == WBP_CAPTURE) && s_d.enable &&
			!(s_d.flush && !s_d.in_txn);
	end

	// state register
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_q <= '0;
			s_q.st <= WBP_CAPTURE;
			s_q.enable <= WBP_CTRL_RESET[WBP_CTRL_ENABLE];
			s_q.waitreq <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// every output straight from the state register
	assign avs_readdata_o = s_q.rdata;
	assign avs_waitrequest_o = s_q.waitreq;
	assign mon_ready_o = s_q.mon_ready;
	assign pkt_data_o = s_q.od;
	assign pkt_valid_o = s_q.ov;
	assign pkt_sop_o = s_q.osop;
	assign pkt_eop_o = s_q.oeop;

endmodule
`default_nettype wire

//--- verilog/wbp_word_fmt.sv
// formats one 26-bit bus word into two 16-bit halves
// purely combinational; the caller registers the result
`timescale 1ns/100ps
`default_nettype none
module wbp_word_fmt import wbp_pkg::*; (
	input wire logic [25:0] word_i,           // raw bus word, sync and parity
	input wire logic [2:0] bus_i,             // source_bus_code
	input wire logic [WBP_GAP_W-1:0] gap_i,   // gap in 50 ns counts
	input wire logic gap_valid_i,             // gap measured for this word
	input wire logic bit_err_i,               // manchester error seen
	input wire logic par_err_i,               // parity error seen
	output logic [15:0] hi_o,                 // first half
	output logic [15:0] lo_o                  // second half
);

	localparam int G1 = WBP_GAP_T1_NS / WBP_GAP_UNIT_NS;
	localparam int G3 = WBP_GAP_T3_NS / WBP_GAP_UNIT_NS;
	localparam int G4 = WBP_GAP_T4_NS / WBP_GAP_UNIT_NS;
	localparam int G5 = WBP_GAP_T5_NS / WBP_GAP_UNIT_NS;
	localparam int G6 = WBP_GAP_T6_NS / WBP_GAP_UNIT_NS;
	localparam int G7 = WBP_GAP_T7_NS / WBP_GAP_UNIT_NS;

	logic [2:0] gap_code;

	// band lookup; code 2 shares its band with code 3, so 3 is used
	always_comb begin
		if (!gap_valid_i)
			gap_code = WBP_GAP_NA;
		else if (gap_i > WBP_GAP_W'(G7))
			gap_code = WBP_GAP_B7;
		else if (gap_i > WBP_GAP_W'(G6))
			gap_code = WBP_GAP_B6;
		else if (gap_i > WBP_GAP_W'(G5))
			gap_code = WBP_GAP_B5;
		else if (gap_i > WBP_GAP_W'(G4))
			gap_code = WBP_GAP_B4;
		else if (gap_i > WBP_GAP_W'(G3))
			gap_code = WBP_GAP_B3;
		else if (gap_i > WBP_GAP_W'(G1))
			gap_code = WBP_GAP_B1;
		else
			gap_code = WBP_GAP_NA; // R19
	end

	// sync bit 25 and parity bit 0 are dropped
	assign hi_o = {bus_i, gap_code, bit_err_i, par_err_i, // R15 R16 R17 R18
		word_i[24:17]}; // R20 R21
	assign lo_o = word_i[16:1]; // R16

endmodule
`default_nettype wire
